// [src/dacc_regs.svh]
`ifndef DACC_REGS_SVH
`define DACC_REGS_SVH

// Calibrate request qualification, in sample clocks
`define DACC_QUAL_CYCLES  7'd80
`define DACC_QUAL_ONE     7'd1

// Pipeline latency, in sample clocks
`define DACC_LAT_PROMPT   4'hd
`define DACC_LAT_DELAYED  4'he

// Power-up delay and calibration length, in sample clocks
`define DACC_DLY_SHORT    32'h0200_0000
`define DACC_DLY_LONG     32'h8000_0000
`define DACC_CAL_LEN      32'h0000_0400
`define DACC_CNT_ONE      32'h0000_0001

// Offset binary coding
`define DACC_CODE_MID     11'sh080
`define DACC_CODE_TOP     11'sh0ff
`define DACC_CODE_MIN     8'h00
`define DACC_CODE_MAX     8'hff

// Three-state pin reading
`define DACC_TRI_LOW      2'h0
`define DACC_TRI_HIGH     2'h1
`define DACC_TRI_FLOAT    2'h2

// Sample store, output buffer and start-up count
`define DACC_MEM_AW       4
`define DACC_MEM_DEPTH    16
`define DACC_BUF_FULL     2'h2
`define DACC_INIT_DONE    2'h3

`endif

// [src/dacc_pkg.sv]
package dacc_pkg;

	typedef enum {
		CAL_WAIT,
		CAL_IDLE,
		CAL_RUN
	} dacc_cal_state_t;

	typedef logic [1:0] dacc_tri_t;

	typedef struct packed {
		logic       over;
		logic [7:0] i;
		logic [7:0] q;
	} dacc_sample_t;

	typedef struct packed {
		logic       over;
		logic [7:0] ip;
		logic [7:0] id;
		logic [7:0] qp;
		logic [7:0] qd;
	} dacc_word_t;

endpackage : dacc_pkg

// [src/dacc_mem_if.sv]
`include "dacc_regs.svh"

interface dacc_mem_if;
	import dacc_pkg::*;

	logic                      wr_en;
	logic [`DACC_MEM_AW-1:0]   wr_addr;
	dacc_sample_t              wr_data;
	logic [`DACC_MEM_AW-1:0]   rd_addr_p;
	logic [`DACC_MEM_AW-1:0]   rd_addr_d;
	dacc_sample_t              rd_data_p;
	dacc_sample_t              rd_data_d;

	modport ctrl (
		output wr_en, wr_addr, wr_data, rd_addr_p, rd_addr_d,
		input  rd_data_p, rd_data_d
	);

	modport mem (
		input  wr_en, wr_addr, wr_data, rd_addr_p, rd_addr_d,
		output rd_data_p, rd_data_d
	);

endinterface : dacc_mem_if

// [src/dacc_sample_mem.sv]
`include "dacc_regs.svh"

module dacc_sample_mem (
	input  wire logic clk_i,
	dacc_mem_if.mem   mem
);
	import dacc_pkg::*;

	dacc_sample_t store [`DACC_MEM_DEPTH];

	// Both read ports registered; write and reads never share an address
	always_ff @(posedge clk_i) begin
		if (mem.wr_en) begin
			store[mem.wr_addr] <= mem.wr_data;
		end
		mem.rd_data_p <= store[mem.rd_addr_p];
		mem.rd_data_d <= store[mem.rd_addr_d];
	end

endmodule : dacc_sample_mem

// [src/dacc_top.sv]
`include "dacc_regs.svh"

module dacc_top #(
	parameter logic [31:0] DLY_SHORT = `DACC_DLY_SHORT,
	parameter logic [31:0] DLY_LONG  = `DACC_DLY_LONG,
	parameter logic [31:0] CAL_LEN   = `DACC_CAL_LEN
) (
	input  wire logic              clk_i,
	input  wire logic              arst_n_i,
	input  wire logic              sample_clk_i,
	input  wire logic signed [9:0] i_level_i,
	input  wire logic signed [9:0] q_level_i,
	input  wire logic              cal_request_i,
	input  wire logic              power_down_input_i,
	input  wire dacc_pkg::dacc_tri_t startup_delay_select_i,
	input  wire dacc_pkg::dacc_tri_t data_edge_select_i,
	input  wire dacc_pkg::dacc_tri_t full_scale_select_i,
	input  wire logic              output_swing_select_i,
	input  wire logic              ext_ctrl_i,
	input  wire logic              reg_swing_i,
	input  wire logic              reg_edge_i,
	input  wire logic              reg_ddr_i,
	input  wire logic              reg_fsr_i,
	input  wire logic              reg_dly_i,
	input  wire logic              out_ready_i,
	output logic [7:0]             i_channel_prompt_bus_o,
	output logic [7:0]             i_channel_delayed_bus_o,
	output logic [7:0]             q_channel_prompt_bus_o,
	output logic [7:0]             q_channel_delayed_bus_o,
	output logic                   out_of_range_o,
	output logic                   out_valid_o,
	output logic                   output_data_clock_o,
	output logic                   ddr_mode_o,
	output logic                   data_rising_o,
	output logic                   output_swing_o,
	output logic                   full_scale_o,
	output logic                   calibration_in_progress_o,
	output logic                   overflow_o
);
	import dacc_pkg::*;

	// Input synchronisers
	logic [2:0]        sclk_s;
	logic [1:0]        cal_s;
	logic [1:0]        pd_s;
	logic [1:0]        swing_s;
	logic [1:0]        ext_s;
	dacc_tri_t         dly_s0;
	dacc_tri_t         dly_s1;
	dacc_tri_t         edge_s0;
	dacc_tri_t         edge_s1;
	dacc_tri_t         fsr_s0;
	dacc_tri_t         fsr_s1;
	logic signed [9:0] ilev_s0;
	logic signed [9:0] ilev_s1;
	logic signed [9:0] qlev_s0;
	logic signed [9:0] qlev_s1;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sclk_s  <= 3'h0;
			cal_s   <= 2'h0;
			pd_s    <= 2'h0;
			swing_s <= 2'h0;
			ext_s   <= 2'h0;
			dly_s0  <= `DACC_TRI_LOW;
			dly_s1  <= `DACC_TRI_LOW;
			edge_s0 <= `DACC_TRI_LOW;
			edge_s1 <= `DACC_TRI_LOW;
			fsr_s0  <= `DACC_TRI_LOW;
			fsr_s1  <= `DACC_TRI_LOW;
			ilev_s0 <= 10'sh000;
			ilev_s1 <= 10'sh000;
			qlev_s0 <= 10'sh000;
			qlev_s1 <= 10'sh000;
		end else begin
			sclk_s  <= {sclk_s[1:0], sample_clk_i};
			cal_s   <= {cal_s[0], cal_request_i};
			pd_s    <= {pd_s[0], power_down_input_i};
			swing_s <= {swing_s[0], output_swing_select_i};
			ext_s   <= {ext_s[0], ext_ctrl_i};
			dly_s0  <= startup_delay_select_i;
			dly_s1  <= dly_s0;
			edge_s0 <= data_edge_select_i;
			edge_s1 <= edge_s0;
			fsr_s0  <= full_scale_select_i;
			fsr_s1  <= fsr_s0;
			ilev_s0 <= i_level_i;
			ilev_s1 <= ilev_s0;
			qlev_s0 <= q_level_i;
			qlev_s1 <= qlev_s0;
		end
	end

	// Falling sample clock edge drives conversion and the qualification, delay and calibration counts
	wire sample_evt = sclk_s[2] & ~sclk_s[1];
	wire cal_lvl    = cal_s[1];
	wire pd         = pd_s[1];

	// Pin reads high only when driven high; a floating pin reads as low
	function automatic logic tri_high(input dacc_tri_t pin);
		tri_high = (pin == `DACC_TRI_HIGH);
	endfunction : tri_high

	// Offset binary code with clamping; top bit flags out of range
	function automatic logic [8:0] to_code(input logic signed [9:0] lvl);
		logic signed [10:0] sum;
		sum = {lvl[9], lvl} + `DACC_CODE_MID;
		if (sum < 11'sh000) begin
			to_code = {1'b1, `DACC_CODE_MIN};
		end else if (sum > `DACC_CODE_TOP) begin
			to_code = {1'b1, `DACC_CODE_MAX};
		end else begin
			to_code = {1'b0, sum[7:0]};
		end
	endfunction : to_code

	// Start-up capture of mode and request level after synchronisers settle
	logic [1:0] init_cnt;
	logic       init_done;
	logic       ext_mode;
	logic       suppress;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			init_cnt  <= 2'h0;
			init_done <= 1'b0;
			ext_mode  <= 1'b0;
			suppress  <= 1'b0;
		end else if (!init_done) begin
			init_cnt <= init_cnt + 2'h1;
			if (init_cnt == `DACC_INIT_DONE) begin
				init_done <= 1'b1;
				ext_mode  <= ext_s[1];
				suppress  <= cal_lvl;
			end
		end
	end

	// Effective controls: register values replace pins in extended mode
	wire eff_ddr   = ext_mode ? reg_ddr_i   : (edge_s1 == `DACC_TRI_FLOAT);
	wire eff_rise  = ext_mode ? reg_edge_i  : tri_high(edge_s1);
	wire eff_fsr   = ext_mode ? reg_fsr_i   : tri_high(fsr_s1);
	wire eff_dly   = ext_mode ? reg_dly_i   : tri_high(dly_s1);
	wire eff_swing = ext_mode ? reg_swing_i : swing_s[1];

	// Calibrate request qualification
	logic       qual_lvl;
	logic [6:0] qual_cnt;
	logic       low_ok;

	wire lvl_change = cal_lvl != qual_lvl;
	wire cnt_sat    = qual_cnt == `DACC_QUAL_CYCLES;
	wire cmd_fire   = sample_evt & ~lvl_change & qual_lvl & low_ok
		& (qual_cnt == `DACC_QUAL_CYCLES - `DACC_QUAL_ONE);

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			qual_lvl <= 1'b1;
			qual_cnt <= 7'h00;
			low_ok   <= 1'b0;
		end else if (sample_evt) begin
			if (lvl_change) begin
				qual_lvl <= cal_lvl;
				qual_cnt <= `DACC_QUAL_ONE;
				if (!cal_lvl) begin
					low_ok <= 1'b0;
				end
			end else begin
				if (!cnt_sat) begin
					qual_cnt <= qual_cnt + `DACC_QUAL_ONE;
				end
				if (!qual_lvl && qual_cnt == `DACC_QUAL_CYCLES - `DACC_QUAL_ONE) begin
					low_ok <= 1'b1;
				end
				if (cmd_fire) begin
					low_ok <= 1'b0;
				end
			end
		end
	end

	// Calibration sequencer
	dacc_cal_state_t state;
	dacc_cal_state_t next_state;
	logic [31:0]     dly_cnt;
	logic [31:0]     next_dly_cnt;
	logic [31:0]     cal_cnt;
	logic [31:0]     next_cal_cnt;

	wire [31:0] dly_target = eff_dly ? DLY_LONG : DLY_SHORT;

	always_comb begin
		next_state   = state;
		next_dly_cnt = dly_cnt;
		next_cal_cnt = cal_cnt;
		case (state)
			CAL_WAIT: begin
				if (init_done && !pd && cmd_fire) begin
					next_state   = CAL_RUN;
					next_cal_cnt = 32'h0;
				end else if (init_done && !pd && sample_evt) begin
					next_dly_cnt = dly_cnt + `DACC_CNT_ONE;
					if (next_dly_cnt >= dly_target) begin
						next_state   = suppress ? CAL_IDLE : CAL_RUN;
						next_cal_cnt = 32'h0;
					end
				end
			end
			CAL_IDLE: begin
				if (cmd_fire && !pd) begin
					next_state   = CAL_RUN;
					next_cal_cnt = 32'h0;
				end
			end
			CAL_RUN: begin
				if (pd) begin
					next_state = CAL_IDLE;
				end else if (sample_evt) begin
					next_cal_cnt = cal_cnt + `DACC_CNT_ONE;
					if (next_cal_cnt >= CAL_LEN) begin
						next_state = CAL_IDLE;
					end
				end
			end
			default: begin
				next_state = CAL_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state   <= CAL_WAIT;
			dly_cnt <= 32'h0;
			cal_cnt <= 32'h0;
		end else begin
			state   <= next_state;
			dly_cnt <= next_dly_cnt;
			cal_cnt <= next_cal_cnt;
		end
	end

	assign calibration_in_progress_o = (state == CAL_RUN);

	// Sample store: one entry per accepted sample clock
	dacc_mem_if mem_bus ();

	dacc_sample_mem u_mem (
		.clk_i (clk_i),
		.mem   (mem_bus.mem)
	);

	logic [`DACC_MEM_AW-1:0] wp;
	logic                    phase;
	logic                    rd_pend;

	wire [8:0] i_code = to_code(ilev_s1);
	wire [8:0] q_code = to_code(qlev_s1);
	wire       take   = sample_evt & ~pd;

	assign mem_bus.wr_en          = take;
	assign mem_bus.wr_addr        = wp;
	assign mem_bus.wr_data.over   = i_code[8] | q_code[8];
	assign mem_bus.wr_data.i      = i_code[7:0];
	assign mem_bus.wr_data.q      = q_code[7:0];
	assign mem_bus.rd_addr_p      = wp - `DACC_LAT_PROMPT;
	assign mem_bus.rd_addr_d      = wp - `DACC_LAT_DELAYED;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wp      <= 4'h0;
			phase   <= 1'b0;
			rd_pend <= 1'b0;
		end else begin
			rd_pend <= take & phase;
			if (take) begin
				wp    <= wp + 4'h1;
				phase <= ~phase;
			end
		end
	end

	// Word stage, stalled by a full buffer
	dacc_word_t stage_w;
	logic       stage_v;
	logic [1:0] buf_cnt;
	dacc_word_t buf0;
	dacc_word_t buf1;

	wire buf_ready = buf_cnt != `DACC_BUF_FULL;
	wire push      = stage_v & buf_ready;
	wire pop       = out_valid_o & out_ready_i;

	dacc_word_t new_w;
	assign new_w.over = mem_bus.rd_data_p.over | mem_bus.rd_data_d.over;
	assign new_w.ip   = mem_bus.rd_data_p.i;
	assign new_w.id   = mem_bus.rd_data_d.i;
	assign new_w.qp   = mem_bus.rd_data_p.q;
	assign new_w.qd   = mem_bus.rd_data_d.q;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			stage_w    <= '0;
			stage_v    <= 1'b0;
			overflow_o <= 1'b0;
		end else if (rd_pend) begin
			stage_w <= new_w;
			stage_v <= 1'b1;
			if (stage_v && !push) begin
				overflow_o <= 1'b1;
			end
		end else if (push) begin
			stage_v <= 1'b0;
		end
	end

	// Two-entry buffer; head entry drives the buses and holds after draining
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			buf_cnt <= 2'h0;
			buf0    <= '0;
			buf1    <= '0;
		end else begin
			if (push && pop) begin
				if (buf_cnt == 2'h1) begin
					buf0 <= stage_w;
				end else begin
					buf0 <= buf1;
					buf1 <= stage_w;
				end
			end else if (push) begin
				buf_cnt <= buf_cnt + 2'h1;
				if (buf_cnt == 2'h0) begin
					buf0 <= stage_w;
				end else begin
					buf1 <= stage_w;
				end
			end else if (pop) begin
				buf_cnt <= buf_cnt - 2'h1;
				if (buf_cnt == `DACC_BUF_FULL) begin
					buf0 <= buf1;
				end
			end
		end
	end

	assign out_valid_o             = buf_cnt != 2'h0;
	assign i_channel_prompt_bus_o  = buf0.ip;
	assign i_channel_delayed_bus_o = buf0.id;
	assign q_channel_prompt_bus_o  = buf0.qp;
	assign q_channel_delayed_bus_o = buf0.qd;
	assign out_of_range_o          = buf0.over;

	// Output data clock: toggles per word in DDR, pulses per word in SDR
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			output_data_clock_o <= 1'b0;
		end else if (pop) begin
			output_data_clock_o <= eff_ddr ? ~output_data_clock_o : eff_rise;
		end else if (!eff_ddr) begin
			output_data_clock_o <= ~eff_rise;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ddr_mode_o     <= 1'b0;
			data_rising_o  <= 1'b0;
			output_swing_o <= 1'b0;
			full_scale_o   <= 1'b0;
		end else begin
			ddr_mode_o     <= eff_ddr;
			data_rising_o  <= eff_rise;
			output_swing_o <= eff_swing;
			full_scale_o   <= eff_fsr;
		end
	end

endmodule : dacc_top

// [testbench/dacc_top_checker.sv]
module dacc_top_checker #(
	parameter logic [31:0] CAL_LEN = 32'h0000_0400
) (
	input  wire logic       clk_i,
	input  wire logic       arst_n_i,
	input  wire logic       sample_clk_i,
	input  wire logic       power_down_input_i,
	input  wire logic       out_ready_i,
	input  wire logic [7:0] i_channel_prompt_bus_o,
	input  wire logic [7:0] i_channel_delayed_bus_o,
	input  wire logic [7:0] q_channel_prompt_bus_o,
	input  wire logic [7:0] q_channel_delayed_bus_o,
	input  wire logic       out_of_range_o,
	input  wire logic       out_valid_o,
	input  wire logic       output_data_clock_o,
	input  wire logic       ddr_mode_o,
	input  wire logic       data_rising_o,
	input  wire logic       calibration_in_progress_o,
	input  wire logic       overflow_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);

	logic [2:0]  smp_sync;
	logic [3:0]  pd_hist;
	logic [31:0] cal_events;
	wire         smp_fall   = smp_sync[2] & ~smp_sync[1];
	wire         pop        = out_valid_o & out_ready_i;
	wire         pd_recent  = power_down_input_i | (|pd_hist);
	wire         clamp_seen = (&i_channel_prompt_bus_o) | (~|i_channel_prompt_bus_o)
		| (&i_channel_delayed_bus_o) | (~|i_channel_delayed_bus_o)
		| (&q_channel_prompt_bus_o) | (~|q_channel_prompt_bus_o)
		| (&q_channel_delayed_bus_o) | (~|q_channel_delayed_bus_o);

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			smp_sync <= 3'h0;
			pd_hist <= 4'h0;
			cal_events <= 32'h0;
		end else begin
			smp_sync <= {smp_sync[1:0], sample_clk_i};
			pd_hist <= {pd_hist[2:0], power_down_input_i};
			cal_events <= calibration_in_progress_o ? cal_events + {31'h0, smp_fall} : 32'h0;
		end
	end

	chk_cal_bounded: assert property (cal_events <= CAL_LEN + 32'h2)
		else $error("calibration outlasted its length");
	chk_cal_holds: assert property ($rose(calibration_in_progress_o) && !pd_recent |=> calibration_in_progress_o [*3])
		else $error("calibration dropped early");
	chk_pd_blocks: assert property (power_down_input_i [*5] |-> !calibration_in_progress_o)
		else $error("calibration active in power down");
	chk_pd_freeze: assert property (power_down_input_i [*8] ##0 !out_valid_o |=> !out_valid_o && $stable(i_channel_prompt_bus_o))
		else $error("output changed in power down");
	chk_clamp_code: assert property (out_valid_o && out_of_range_o |-> clamp_seen)
		else $error("range flag without clamped code");
	chk_head_hold: assert property (out_valid_o && !out_ready_i |=> out_valid_o && $stable(i_channel_delayed_bus_o) && $stable(q_channel_prompt_bus_o))
		else $error("head word changed while stalled");
	chk_ovf_sticky: assert property (overflow_o |=> overflow_o)
		else $error("overflow flag cleared");
	// Mode outputs lag the live setting by one clock, so judge the pop by the mode shown after it
	chk_ddr_clock: assert property (pop |=> !ddr_mode_o || output_data_clock_o != $past(output_data_clock_o))
		else $error("data clock did not toggle");
	chk_sdr_clock: assert property (pop |=> ddr_mode_o || output_data_clock_o == data_rising_o)
		else $error("data clock edge level wrong");

	cover property ($rose(calibration_in_progress_o));
	cover property (pop && out_of_range_o);
	cover property ($rose(overflow_o));
endmodule : dacc_top_checker

bind dacc_top dacc_top_checker #(.CAL_LEN(CAL_LEN)) i_chk (
	.clk_i, .arst_n_i, .sample_clk_i, .power_down_input_i, .out_ready_i,
	.i_channel_prompt_bus_o, .i_channel_delayed_bus_o, .q_channel_prompt_bus_o, .q_channel_delayed_bus_o,
	.out_of_range_o, .out_valid_o, .output_data_clock_o, .ddr_mode_o, .data_rising_o,
	.calibration_in_progress_o, .overflow_o
);

// [testbench/dacc_rx_model.sv]
module dacc_rx_model (
	input  wire logic clk_i,
	input  wire logic arst_n_i,
	input  wire logic out_valid_i,
	input  wire logic stall_i,
	output logic      out_ready_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int unsigned samples = 0;

	initial out_ready_o = 1'b0;
	// Random back-pressure, forced low while stalled
	always @(negedge clk_i) begin
		out_ready_o <= !stall_i && (($urandom % 4) != 0);
	end
	// Each popped word carries two samples per channel
	always @(posedge clk_i) begin
		if (arst_n_i && out_valid_i && out_ready_o)
			samples <= samples + 2;
	end
endmodule : dacc_rx_model

// [testbench/dacc_top_test.sv]
`include "dacc_regs.svh"

module dacc_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	import dacc_pkg::*;

	logic       clk = 1'b0;
	logic       rst_n = 1'b0;
	logic       smp_clk = 1'b1;
	logic [9:0] i_lvl = 10'h000;
	logic [9:0] q_lvl = 10'h000;
	logic       cal_req = 1'b0;
	logic       pd = 1'b0;
	dacc_tri_t  dly_sel = `DACC_TRI_LOW;
	dacc_tri_t  edge_sel = `DACC_TRI_LOW;
	dacc_tri_t  fs_sel = `DACC_TRI_LOW;
	logic       swing = 1'b0;
	logic       ext = 1'b0;
	logic [4:0] regs = 5'b01000;
	logic       stall = 1'b0;
	logic       rdy;
	logic [7:0] ip, id, qp, qd, last_ip;
	logic       oor, vld, output_data_clock, ddr, rise, swo, fso, cal, ovf;
	int         n_fail = 0;
	int         compares = 0;
	int         lv[8] = '{-300, 300, 0, -128, 127, -129, 128, 5};
	dacc_word_t notes[$];
	dacc_word_t w;

	always #10 clk = ~clk;
	initial begin
		#7;
		forever #80 smp_clk = ~smp_clk;
	end

	dacc_top #(.DLY_SHORT(32'h40), .DLY_LONG(32'h80), .CAL_LEN(32'h10)) i_dut (
		.clk_i(clk), .arst_n_i(rst_n), .sample_clk_i(smp_clk), .i_level_i(i_lvl), .q_level_i(q_lvl),
		.cal_request_i(cal_req), .power_down_input_i(pd), .startup_delay_select_i(dly_sel),
		.data_edge_select_i(edge_sel), .full_scale_select_i(fs_sel), .output_swing_select_i(swing),
		.ext_ctrl_i(ext), .reg_swing_i(regs[4]), .reg_edge_i(regs[3]), .reg_ddr_i(regs[2]),
		.reg_fsr_i(regs[1]), .reg_dly_i(regs[0]), .out_ready_i(rdy),
		.i_channel_prompt_bus_o(ip), .i_channel_delayed_bus_o(id), .q_channel_prompt_bus_o(qp),
		.q_channel_delayed_bus_o(qd), .out_of_range_o(oor), .out_valid_o(vld), .output_data_clock_o(output_data_clock),
		.ddr_mode_o(ddr), .data_rising_o(rise), .output_swing_o(swo), .full_scale_o(fso),
		.calibration_in_progress_o(cal), .overflow_o(ovf)
	);

	dacc_rx_model i_rx (.clk_i(clk), .arst_n_i(rst_n), .out_valid_i(vld), .stall_i(stall), .out_ready_o(rdy));

	task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic end_sim();
		$display("compares %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_sim

	// Ends early in the high phase of the sample clock, away from sampling
	task automatic smp(int n);
		repeat (n) @(negedge smp_clk);
		@(posedge smp_clk);
		@(negedge clk);
	endtask : smp

	task automatic rst(logic e);
		ext = e;
		rst_n = 1'b0;
		repeat (8) @(negedge clk);
		rst_n = 1'b1;
		repeat (8) @(negedge clk);
	endtask : rst

	task automatic wait_cal(logic lvl, int lim);
		int k;
		k = 0;
		while (cal !== lvl && k < lim) begin
			@(negedge clk);
			k++;
		end
		chk("cal_flag", {7'h0, lvl}, {7'h0, cal});
		if (cal !== lvl)
			end_sim();
	endtask : wait_cal

	task automatic cmd(int lo, int hi);
		cal_req = 1'b0;
		smp(lo);
		cal_req = 1'b1;
		smp(hi);
	endtask : cmd

	function automatic logic [8:0] enc(int l);
		if (l < -128)
			return 9'h100;
		if (l > 127)
			return 9'h1ff;
		return {1'b0, 8'(l + 128)};
	endfunction : enc

	always @(posedge clk) begin
		if (vld === 1'b1 && rdy === 1'b1 && notes.size() > 0) begin
			w = notes.pop_front();
			chk("prompt_i", w.ip, ip);
			chk("delayed_i", w.id, id);
			chk("prompt_q", w.qp, qp);
			chk("delayed_q", w.qd, qd);
			chk("range", {7'h0, w.over}, {7'h0, oor});
		end
	end

	initial begin
		void'($urandom(32'h633b));
		for (int m = 0; m < 2; m++) begin
			dly_sel = m ? `DACC_TRI_HIGH : `DACC_TRI_LOW;
			pd = 1'b1;
			rst(1'b0);
			smp(140);
			chk("cal_in_pd", 8'h00, {7'h0, cal});
			pd = 1'b0;
			smp(m ? 124 : 60);
			chk("cal_early", 8'h00, {7'h0, cal});
			wait_cal(1'b1, 160);
			wait_cal(1'b0, 200);
			$display("power-up calibration %0d done", m);
		end
		cal_req = 1'b1;
		rst(1'b0);
		smp(100);
		chk("cal_req_high", 8'h00, {7'h0, cal});
		cmd(40, 0);
		cmd(40, 100);
		chk("split_low", 8'h00, {7'h0, cal});
		cmd(79, 100);
		chk("short_low", 8'h00, {7'h0, cal});
		cmd(80, 79);
		chk("short_high", 8'h00, {7'h0, cal});
		smp(1);
		wait_cal(1'b1, 8);
		pd = 1'b1;
		wait_cal(1'b0, 8);
		cmd(80, 80);
		chk("cal_in_pd", 8'h00, {7'h0, cal});
		pd = 1'b0;
		$display("calibration command done");
		for (int k = 0; k < 12; k++) begin
			int li;
			int lq;
			logic [8:0] ei;
			logic [8:0] eq;
			li = k < 8 ? lv[k] : int'($urandom_range(255)) - 128;
			lq = k < 8 ? lv[7 - k] : int'($urandom_range(255)) - 128;
			i_lvl = 10'(li);
			q_lvl = 10'(lq);
			smp(16);
			ei = enc(li);
			eq = enc(lq);
			last_ip = ei[7:0];
			notes.push_back('{ei[8] | eq[8], ei[7:0], ei[7:0], eq[7:0], eq[7:0]});
		end
		for (int k = 0; k < 400 && notes.size() > 0; k++)
			@(negedge clk);
		chk("notes_left", 8'h00, 8'(notes.size()));
		if (notes.size() > 0)
			end_sim();
		chk("no_loss", 8'h00, {7'h0, ovf});
		pd = 1'b1;
		smp(3);
		i_lvl = 10'h17f;
		smp(20);
		chk("held_i", last_ip, ip);
		pd = 1'b0;
		$display("data path done");
		stall = 1'b1;
		// Four words: two fill the buffer, the fourth overwrites the third in the stage, the third is lost
		smp(8);
		chk("overflow", 8'h01, {7'h0, ovf});
		chk("valid_stall", 8'h01, {7'h0, vld});
		stall = 1'b0;
		for (int k = 0; k < 200 && vld !== 1'b0; k++)
			@(negedge clk);
		chk("drained", 8'h00, {7'h0, vld});
		if (vld !== 1'b0)
			end_sim();
		$display("buffer done");
		fs_sel = `DACC_TRI_HIGH;
		edge_sel = `DACC_TRI_FLOAT;
		swing = 1'b1;
		rst(1'b1);
		chk("mode_ext", 8'h04, {4'h0, ddr, rise, swo, fso});
		rst(1'b0);
		smp(8);
		chk("mode_pin", 8'h07, {5'h0, ddr, swo, fso});
		// Full scale was changed, so the host recalibrates
		cmd(80, 80);
		wait_cal(1'b1, 8);
		ext = 1'b1;
		edge_sel = `DACC_TRI_HIGH;
		smp(8);
		chk("edge_high", 8'h01, {6'h0, ddr, rise});
		edge_sel = `DACC_TRI_LOW;
		repeat (4) @(negedge clk);
		chk("edge_low", 8'h00, {6'h0, ddr, rise});
		$display("mode select done");
		end_sim();
	end
endmodule : dacc_top_test
